// ===== design/rsil_interlock.sv
// Permission and servo interlock logic for door, enabling device, pendant and mode key.
//
// Contract
// RL1: In automatic operation an open door turns servo off, stops the robot and raises an error.
// RL2: After a door stop, servo-on is refused until the door is closed and the alarm is reset.
// RL3: In teaching an open door alone does not block servo-on or pendant jog.
// RL4: With door open in teaching, servo-on and jog need the pendant switch and enabling device.
// RL5: With door open in teaching, releasing the enabling device alone switches servo off at once.
// RL6: With door open and enabling device released, servo-on and brake release are rejected.
// RL7: With door closed in teaching, servo-on through the pendant alone is allowed.
// RL8: Jog needs manual mode, pendant enabled and switch on, and enabling device or door closed.
// RL9: Brake release needs manual mode, pendant enabled, switch on and enabling device closed.
// RL10: Brake release acts only while both enabling device and pendant switch are at mid position.
// RL11: Automatic operation needs automatic mode, pendant disabled and door closed throughout.
// RL12: Key channels both open select manual and both closed select automatic.
// RL13: Disagreeing key channels raise the key line fault and the mode is not accepted.
// RL14: In automatic mode external operations are accepted and pendant operations rejected.
// RL15: In manual mode with pendant available only pendant operations are accepted.
// RL16: The outside party configures the operating right for external equipment in automatic mode.
// RL17: Inputs are synchronised and debounced, and servo-off acts one cycle after detection; the code filters only the switch inputs, not the requests.
`timescale 1ns/100ps
module rsil_interlock
  import rsil_pkg::*;
#(
  parameter int DEBOUNCE_CYCLES = rsil_pkg::DEBOUNCE_CYC
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic door_closed,
  input wire logic endev_closed,
  input wire logic endev_mid,
  input wire logic tb_enabled,
  input wire logic tb_switch_on,
  input wire logic tb_mid,
  input wire logic key_line1_closed,
  input wire logic key_line2_closed,
  input wire logic servo_on_req,
  input wire logic alarm_reset,
  input wire logic ext_op_req,
  input wire logic tb_op_req,
  output logic servo_power,
  output logic jog_allowed,
  output logic brake_release,
  output logic auto_allowed,
  output logic auto_mode,
  output logic door_alarm,
  output logic key_fault,
  output logic ext_op_accept,
  output logic tb_op_accept,
  output logic servo_on_reject
);
  import rsil_pkg::*;

  logic [N_SW-1:0] raw;
  logic [N_SW-1:0] sync1_reg;
  logic [N_SW-1:0] sync2_reg;
  logic [N_SW-1:0] filt_reg;
  logic [N_SW-1:0] filt_next;
  rsil_servo_t servo_reg;
  rsil_servo_t servo_next;
  logic mode_auto_reg;
  logic mode_auto_next;
  logic key_fault_reg;
  logic door, endev, tben, tbsw, k1, k2, endev_m, tb_m;
  logic manual_ok, tb_ctrl, teach_hold, on_ok;
  logic [2:0] out_next;

  assign raw = {tb_mid, endev_mid, key_line2_closed, key_line1_closed,
                tb_switch_on, tb_enabled, endev_closed, door_closed};

  // Two-flop synchroniser for every switch input.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      sync1_reg <= SW_RESET;
      sync2_reg <= SW_RESET;
    end else begin
      sync1_reg <= raw;
      sync2_reg <= sync1_reg;
    end
  end

  // One debounce counter per input; the filtered level follows a stable input.
  genvar gi;
  generate
    for (gi = 0; gi < N_SW; gi++) begin : g_db
      logic [DB_CNT_W-1:0] cnt_reg;
      always_ff @(posedge core_clk) begin
        if (!rst_b) begin
          cnt_reg <= '0;
          filt_reg[gi] <= SW_RESET[gi];
        end else if (sync2_reg[gi] == filt_reg[gi]) begin
          cnt_reg <= '0;
        end else if (cnt_reg >= DB_CNT_W'(DEBOUNCE_CYCLES - 1)) begin
          cnt_reg <= '0;
          filt_reg[gi] <= sync2_reg[gi]; // see RL17
        end else begin
          cnt_reg <= cnt_reg + 1'b1;
        end
      end
      assign filt_next[gi] = filt_reg[gi];
    end
  endgenerate

  assign door = filt_next[SW_DOOR];
  assign endev = filt_next[SW_ENDEV];
  assign tben = filt_next[SW_TB_EN];
  assign tbsw = filt_next[SW_TB_SW];
  assign k1 = filt_next[SW_KEY1];
  assign k2 = filt_next[SW_KEY2];
  assign endev_m = filt_next[SW_ENDEV_MID];
  assign tb_m = filt_next[SW_TB_MID];

  // Mode follows the key only when both channels agree; otherwise the old mode holds.
  always_comb begin
    mode_auto_next = mode_auto_reg;
    if (k1 == k2) begin
      mode_auto_next = k1; // see RL12
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      mode_auto_reg <= 1'b0;
      key_fault_reg <= 1'b0;
    end else begin
      mode_auto_reg <= mode_auto_next; // see RL13
      key_fault_reg <= k1 ^ k2; // see RL13
    end
  end

  // Teaching with the pendant in control.
  assign manual_ok = !mode_auto_reg && !key_fault_reg;
  assign tb_ctrl = manual_ok && tben && tbsw;
  // In teaching the door only matters when the enabling device is released.
  assign teach_hold = tb_ctrl && (endev || door); // see RL3 and RL7
  // Conditions that let servo stay or come on in each mode.
  assign on_ok = mode_auto_reg ? (!key_fault_reg && !tben && door) : teach_hold;

  // Servo state: off, on, or latched alarm after a door stop in automatic.
  always_comb begin
    servo_next = servo_reg;
    unique case (servo_reg)
      RSIL_OFF: begin
        if (servo_on_req && on_ok) begin
          servo_next = RSIL_ON; // see RL4
        end
      end
      RSIL_ON: begin
        if (mode_auto_reg && !door) begin
          servo_next = RSIL_ALARM; // see RL1
        end else if (!on_ok) begin
          servo_next = RSIL_OFF; // see RL5
        end
      end
      RSIL_ALARM: begin
        if (alarm_reset && door) begin
          servo_next = RSIL_OFF; // see RL2
        end
      end
      default: servo_next = RSIL_OFF;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      servo_reg <= RSIL_OFF;
    end else begin
      servo_reg <= servo_next;
    end
  end

  // Registered permission outputs; a mode change in flight drops jog and automatic at once.
  assign out_next[0] = (servo_next == RSIL_ON) && teach_hold && !mode_auto_next; // see RL8
  assign out_next[1] = tb_ctrl && endev && endev_m && tb_m; // see RL9
  assign out_next[2] = (servo_next == RSIL_ON) && mode_auto_reg && mode_auto_next
                       && on_ok; // see RL11

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      servo_power <= 1'b0;
      jog_allowed <= 1'b0;
      brake_release <= 1'b0;
      auto_allowed <= 1'b0;
      door_alarm <= 1'b0;
      servo_on_reject <= 1'b0;
      ext_op_accept <= 1'b0;
      tb_op_accept <= 1'b0;
    end else begin
      servo_power <= (servo_next == RSIL_ON); // see RL17
      jog_allowed <= out_next[0];
      brake_release <= out_next[1]; // see RL10
      auto_allowed <= out_next[2];
      door_alarm <= (servo_next == RSIL_ALARM);
      servo_on_reject <= servo_on_req && (servo_reg != RSIL_ON)
                         && !(servo_reg == RSIL_OFF && on_ok); // see RL6
      ext_op_accept <= ext_op_req && mode_auto_reg && !key_fault_reg; // see RL14
      tb_op_accept <= tb_op_req && manual_ok && tben; // see RL15
    end
  end

  assign auto_mode = mode_auto_reg;
  assign key_fault = key_fault_reg;

  // Door opening in automatic with servo on forces servo off and the alarm next cycle.
  property p_door_stop;
    @(posedge core_clk) disable iff (!rst_b)
      (servo_reg == RSIL_ON && mode_auto_reg && !door) |=> (!servo_power && door_alarm);
  endproperty
  a_door_stop: assert property (p_door_stop) else $error("door stop missed"); // see RL1

  property p_alarm_block;
    @(posedge core_clk) disable iff (!rst_b)
      (servo_reg == RSIL_ALARM && !alarm_reset) |=> !servo_power;
  endproperty
  a_alarm_block: assert property (p_alarm_block) else $error("servo on before reset"); // see RL2

  property p_endev_off;
    @(posedge core_clk) disable iff (!rst_b)
      (!mode_auto_reg && !door && !endev && servo_reg == RSIL_ON) |=> !servo_power;
  endproperty
  a_endev_off: assert property (p_endev_off) else $error("enabling release no off"); // see RL5

  property p_brake_need;
    @(posedge core_clk) disable iff (!rst_b)
      brake_release |-> $past(endev && endev_m && tb_m && tbsw && !mode_auto_reg);
  endproperty
  a_brake_need: assert property (p_brake_need) else $error("brake without grip"); // see RL9

  property p_key_fault;
    @(posedge core_clk) disable iff (!rst_b)
      (k1 != k2) |=> (key_fault && $stable(auto_mode));
  endproperty
  a_key_fault: assert property (p_key_fault) else $error("key fault not flagged"); // see RL13

  property p_key_mode;
    @(posedge core_clk) disable iff (!rst_b)
      (k1 == k2) |=> (auto_mode == $past(k1));
  endproperty
  a_key_mode: assert property (p_key_mode) else $error("mode not from key"); // see RL12

  property p_auto_need;
    @(posedge core_clk) disable iff (!rst_b)
      auto_allowed |-> (auto_mode && $past(door && !tben));
  endproperty
  a_auto_need: assert property (p_auto_need) else $error("auto without door"); // see RL11

  property p_jog_need;
    @(posedge core_clk) disable iff (!rst_b)
      jog_allowed |-> ($past(tbsw && tben && (endev || door)) && !auto_mode);
  endproperty
  a_jog_need: assert property (p_jog_need) else $error("jog without enable"); // see RL8

  property p_tb_reject;
    @(posedge core_clk) disable iff (!rst_b)
      mode_auto_reg |=> !tb_op_accept;
  endproperty
  a_tb_reject: assert property (p_tb_reject) else $error("pendant op in auto"); // see RL14
endmodule // rsil_interlock

// ===== design/rsil_pkg.sv
// Package with constants and types for the robot safety interlock block.
package rsil_pkg;
  // Debounce time in microseconds and the clock period in nanoseconds.
  localparam int DEBOUNCE_US = 10;
  localparam int CLK_PERIOD_NS = 25;
  // Least time rounds up to whole cycles.
  localparam int DEBOUNCE_CYC = (DEBOUNCE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DB_CNT_W = $clog2(DEBOUNCE_CYC + 1);
  // Number of filtered switch inputs and their positions.
  localparam int N_SW = 8;
  localparam int SW_DOOR = 0;
  localparam int SW_ENDEV = 1;
  localparam int SW_TB_EN = 2;
  localparam int SW_TB_SW = 3;
  localparam int SW_KEY1 = 4;
  localparam int SW_KEY2 = 5;
  localparam int SW_ENDEV_MID = 6;
  localparam int SW_TB_MID = 7;
  // Value of the filtered inputs after reset: everything open and released.
  localparam logic [N_SW-1:0] SW_RESET = 8'h00;
  // Servo state machine.
  typedef enum logic [1:0] {
    RSIL_OFF = 2'b00,
    RSIL_ON = 2'b01,
    RSIL_ALARM = 2'b10
  } rsil_servo_t;
endpackage

// ===== dv/rsil_switch_model.sv
// Model of the operator switches, pendant and key switch, with optional contact chatter.
`timescale 1ns/100ps
module rsil_switch_model
  import rsil_pkg::*;
(
  input wire logic core_clk,
  input wire logic [N_SW-1:0] want,
  input wire logic bounce,
  output logic [N_SW-1:0] line
);
  logic [N_SW-1:0] prev_reg = SW_RESET;
  logic [N_SW-1:0] old_reg = SW_RESET;
  logic [1:0] ph_reg = 2'h0;
  // A change starts three cycles of chatter; old_reg keeps the old level until it ends.
  always_ff @(posedge core_clk) begin
    prev_reg <= want;
    if (want != prev_reg) begin
      ph_reg <= 2'h3;
    end else if (ph_reg != 2'h0) begin
      ph_reg <= ph_reg - 2'h1;
    end else begin
      old_reg <= want;
    end
  end
  // Chattering contacts fall back to the old level on alternate cycles.
  assign line = (bounce && ph_reg[0]) ? old_reg : want;
endmodule // rsil_switch_model

// ===== dv/robot_safety_interlock_mode_logic_test.sv
// Self-checking testbench for the robot safety interlock block.
`timescale 1ns/100ps
module robot_safety_interlock_mode_logic_test;
  import rsil_pkg::*;
  localparam logic [N_SW-1:0] DR = 8'h01 << SW_DOOR;
  localparam logic [N_SW-1:0] ED = 8'h01 << SW_ENDEV;
  localparam logic [N_SW-1:0] EM = 8'h01 << SW_ENDEV_MID;
  localparam logic [N_SW-1:0] TE = 8'h01 << SW_TB_EN;
  localparam logic [N_SW-1:0] TS = 8'h01 << SW_TB_SW;
  localparam logic [N_SW-1:0] TM = 8'h01 << SW_TB_MID;
  localparam logic [N_SW-1:0] K1 = 8'h01 << SW_KEY1;
  localparam logic [N_SW-1:0] K2 = 8'h01 << SW_KEY2;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic bounce = 1'b0;
  logic [N_SW-1:0] want = SW_RESET;
  logic [N_SW-1:0] line;
  logic [3:0] req = 4'h0;
  logic servo_power, jog_allowed, brake_release, auto_allowed, auto_mode;
  logic door_alarm, key_fault, ext_op_accept, tb_op_accept, servo_on_reject;
  int mismatches = 0;
  int tests_run = 0;
  // Clock of 25 ns.
  always #12.5 core_clk = ~core_clk;
  rsil_switch_model PM (.core_clk(core_clk), .want(want), .bounce(bounce), .line(line));
  rsil_interlock #(.DEBOUNCE_CYCLES(2)) DUT (.core_clk(core_clk), .rst_b(rst_b),
    .door_closed(line[SW_DOOR]), .endev_closed(line[SW_ENDEV]), .endev_mid(line[SW_ENDEV_MID]),
    .tb_enabled(line[SW_TB_EN]), .tb_switch_on(line[SW_TB_SW]), .tb_mid(line[SW_TB_MID]),
    .key_line1_closed(line[SW_KEY1]), .key_line2_closed(line[SW_KEY2]),
    .servo_on_req(req[0]), .alarm_reset(req[1]), .ext_op_req(req[2]), .tb_op_req(req[3]),
    .servo_power(servo_power), .jog_allowed(jog_allowed), .brake_release(brake_release),
    .auto_allowed(auto_allowed), .auto_mode(auto_mode), .door_alarm(door_alarm),
    .key_fault(key_fault), .ext_op_accept(ext_op_accept), .tb_op_accept(tb_op_accept),
    .servo_on_reject(servo_on_reject));
  task step(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task chk(input string n, input logic s, input logic e);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %b seen %b", n, e, s);
    end
  endtask
  // Ten cycles cover chatter, two sync flops, the filter and the output register.
  task sw(input logic [N_SW-1:0] v);
    want <= v;
    step(10);
  endtask
  task close_out;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task t_teach_closed;
    sw(TE | TS | DR);
    req <= 4'h1;
    step(3);
    chk("servo_power", servo_power, 1'b1);
    chk("jog_allowed", jog_allowed, 1'b1);
    chk("brake_release", brake_release, 1'b0);
    req <= 4'h0;
  endtask
  task t_teach_open;
    sw(TE | TS | TM | ED | EM);
    req <= 4'h1;
    step(3);
    chk("servo_power", servo_power, 1'b1);
    chk("door_alarm", door_alarm, 1'b0);
    chk("jog_allowed", jog_allowed, 1'b1);
    chk("brake_release", brake_release, 1'b1);
    req <= 4'h0;
    sw(TE | TS | ED);
    chk("brake_release", brake_release, 1'b0);
    chk("jog_allowed", jog_allowed, 1'b1);
    sw(TE | TS);
    chk("servo_power", servo_power, 1'b0);
    chk("jog_allowed", jog_allowed, 1'b0);
    req <= 4'h1;
    step(3);
    chk("servo_on_reject", servo_on_reject, 1'b1);
    chk("servo_power", servo_power, 1'b0);
    chk("brake_release", brake_release, 1'b0);
    req <= 4'h0;
    sw(TE | TS | ED);
    req <= 4'h1;
    step(3);
    chk("servo_power", servo_power, 1'b1);
    req <= 4'h0;
    sw(TE | ED);
    chk("servo_power", servo_power, 1'b0);
    chk("jog_allowed", jog_allowed, 1'b0);
  endtask
  task t_auto;
    int i;
    sw(K1 | K2 | DR);
    chk("auto_mode", auto_mode, 1'b1);
    req <= 4'hD;
    step(3);
    chk("servo_power", servo_power, 1'b1);
    chk("auto_allowed", auto_allowed, 1'b1);
    chk("ext_op_accept", ext_op_accept, 1'b1);
    chk("tb_op_accept", tb_op_accept, 1'b0);
    req <= 4'h0;
    bounce <= 1'b1;
    want <= K1 | K2;
    step(2);
    chk("servo_power", servo_power, 1'b1);
    for (i = 0; i < 20 && servo_power !== 1'b0; i++) step(1);
    if (i == 20) begin
      chk("servo_power", servo_power, 1'b0);
      close_out();
    end
    chk("door_alarm", door_alarm, 1'b1);
    chk("auto_allowed", auto_allowed, 1'b0);
    sw(K1 | K2 | DR);
    req <= 4'h1;
    step(3);
    chk("servo_power", servo_power, 1'b0);
    chk("servo_on_reject", servo_on_reject, 1'b1);
    req <= 4'h2;
    step(1);
    req <= 4'h0;
    step(2);
    chk("door_alarm", door_alarm, 1'b0);
    req <= 4'h1;
    step(3);
    chk("servo_power", servo_power, 1'b1);
    req <= 4'h0;
    bounce <= 1'b0;
  endtask
  task t_key;
    sw(K1 | DR);
    chk("key_fault", key_fault, 1'b1);
    chk("auto_mode", auto_mode, 1'b1);
    chk("auto_allowed", auto_allowed, 1'b0);
    sw(TE | TS | DR);
    chk("key_fault", key_fault, 1'b0);
    chk("auto_mode", auto_mode, 1'b0);
    req <= 4'hC;
    step(3);
    chk("tb_op_accept", tb_op_accept, 1'b1);
    chk("ext_op_accept", ext_op_accept, 1'b0);
    req <= 4'h0;
  endtask
  // Reset for five cycles, then run every scenario in turn.
  initial begin
    step(5);
    chk("servo_power", servo_power, 1'b0);
    chk("auto_mode", auto_mode, 1'b0);
    rst_b <= 1'b1;
    step(3);
    t_teach_closed();
    t_teach_open();
    t_auto();
    t_key();
    close_out();
  end
endmodule // robot_safety_interlock_mode_logic_test
